// ==== core/mmr_params.svh ====
// Constants for the motor measurement readback bank: indices, fields, codes, resets
`ifndef MMR_PARAMS_SVH
`define MMR_PARAMS_SVH

// Register indices as printed; byte address is four times the index
`define MMR_IDX_THIRD_LEG_CURRENT 14'h0442
`define MMR_IDX_SENSE_AMP_GAIN 14'h0466
`define MMR_IDX_VOLTAGE_RANGE 14'h0476
`define MMR_IDX_SUPPLY_RAIL 14'h0478
`define MMR_IDX_FIRST_LEG_VOLTAGE 14'h047E
`define MMR_IDX_SAMPLE_CONTROL 14'h04F0

// Reset value of every sample holder and of the read data register
`define MMR_RESET_WORD 32'h00000000

// Code fields of the gain and range reports sit in the low half-word
`define MMR_CODE_MSB 15
`define MMR_CODE_LSB 0

// Fixed-point full scale is two to this power
`define MMR_FULL_SCALE_EXP 27

// Sense-amplifier gain codes: 1.2, 0.6, 0.3 and 0.15 V/A
`define MMR_GAIN_MAX_CODE 16'h0003
// Voltage range codes: 60 V, 30 V and 15 V
`define MMR_RANGE_MAX_CODE 16'h0002

// Control state code reported while initial spin detection runs
`define MMR_STATE_SPIN_DETECT 16'h0001

// Sample control register fields
`define MMR_CTRL_FREEZE_BIT 0
`define MMR_CTRL_CAPTURED_BIT 8
`define MMR_CTRL_SPIN_ACTIVE_BIT 9
`define MMR_CTRL_GAIN_OK_BIT 10
`define MMR_CTRL_RANGE_OK_BIT 11
`define MMR_CTRL_COUNT_LSB 16
`define MMR_CTRL_COUNT_MSB 31

`endif

// ==== core/mmr_pkg.sv ====
// Types shared by the motor measurement readback bank
package mmr_pkg;

  typedef logic [15:0] mmr_addr_t;
  typedef logic [31:0] mmr_word_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    mmr_addr_t paddr;
    mmr_word_t pwdata;
    logic [3:0] pstrb;
  } mmr_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    mmr_word_t prdata;
  } mmr_apb_rsp_t;

  // Live measurements from the control core
  typedef struct packed {
    mmr_word_t thirdLegCurrent;
    logic [15:0] senseAmpGainCode;
    logic [15:0] voltageRangeCode;
    mmr_word_t supplyRailLevel;
    mmr_word_t firstLegVoltage;
  } mmr_meas_t;

  // Channel order of the sample-and-hold array
  typedef enum int {
    MMR_CH_CURRENT = 0,
    MMR_CH_GAIN = 1,
    MMR_CH_RANGE = 2,
    MMR_CH_SUPPLY = 3,
    MMR_CH_VOLTAGE = 4
  } mmr_chan_t;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    MMR_IDLE = 2'b01,
    MMR_ACCESS = 2'b10
  } mmr_bus_state_t;

endpackage

// ==== core/mmr_sample_hold.sv ====
// One sample-and-hold word of the readback bank
`timescale 1ns/10ps
`include "mmr_params.svh"

module mmr_sample_hold
  import mmr_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataOut
);

  logic [WIDTH-1:0] hold_reg;

  // Holds the last loaded sample; clears to zero on reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hold_reg <= WIDTH'(`MMR_RESET_WORD);
    end
    else if (load)
    begin
      hold_reg <= dataIn;
    end
  end

  assign dataOut = hold_reg;

endmodule

// ==== core/mmr_readback.sv ====
// Motor measurement readback bank behind an APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`include "mmr_params.svh"

module mmr_readback
  import mmr_pkg::*;
#(
  parameter int CHANNELS = 5
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire mmr_apb_req_t apbReq,
  output mmr_apb_rsp_t apbRsp,
  input wire mmr_meas_t meas,
  input wire logic measStrobe,
  input wire logic [15:0] spinDetectState
)
;

  // Bus state, answer and control registers
  mmr_bus_state_t state_reg;
  mmr_bus_state_t state_next;
  mmr_word_t prdata_reg;
  mmr_word_t prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic freeze_reg;
  logic captured_reg;
  logic [15:0] count_reg;

  // Decode nets and the per-channel datapath
  logic [13:0] regIndex;
  logic wordAligned;
  logic setupPhase;
  logic accessDone;
  logic ctrlWrite;
  logic spinActive;
  logic gainOk;
  logic rangeOk;
  logic sampleTake;
  logic [CHANNELS-1:0] chanLoad;
  mmr_word_t chanIn [CHANNELS];
  mmr_word_t chanOut [CHANNELS];
  mmr_word_t ctrlWord;

  // Address split: word index above, byte offset below
  assign regIndex = apbReq.paddr[15:2];
  assign wordAligned = (apbReq.paddr[1:0] == 2'h0);
  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessDone = (state_reg == MMR_ACCESS) && apbReq.psel && apbReq.penable;

  // Only the sample control word accepts writes; all others drop them
  assign ctrlWrite = accessDone && apbReq.pwrite && wordAligned &&
                     (regIndex == `MMR_IDX_SAMPLE_CONTROL) && apbReq.pstrb[0];

  // Spin detection window from the control state code
  // Only the exact code counts; every other state leaves the capture alone
  assign spinActive = (spinDetectState == `MMR_STATE_SPIN_DETECT);

  // Code sanity as seen on the live inputs
  // Out-of-range codes are still held as given; the flags only report them
  assign gainOk = (meas.senseAmpGainCode <= `MMR_GAIN_MAX_CODE);
  assign rangeOk = (meas.voltageRangeCode <= `MMR_RANGE_MAX_CODE);

  // Freeze lets software read a coherent set while the core keeps running
  // A strobe held high samples on every cycle that it stands
  assign sampleTake = measStrobe && !freeze_reg;

  // Channel inputs; code channels carry zeros in the upper half-word
  // The upper halves are reserved, so read decode forces them to zero again
  always_comb
  begin
    chanIn[MMR_CH_CURRENT] = meas.thirdLegCurrent;
    chanIn[MMR_CH_GAIN] = {16'h0000, meas.senseAmpGainCode};
    chanIn[MMR_CH_RANGE] = {16'h0000, meas.voltageRangeCode};
    chanIn[MMR_CH_SUPPLY] = meas.supplyRailLevel;
    chanIn[MMR_CH_VOLTAGE] = meas.firstLegVoltage;
  end

  // Load strobes; the first-leg voltage only moves during spin detection
  // Outside spin detection the last captured voltage stays readable
  always_comb
  begin
    chanLoad = {CHANNELS{sampleTake}};
    chanLoad[MMR_CH_VOLTAGE] = sampleTake && spinActive;
  end

  // One holder per reported value, all cleared to zero by reset
  // Flip-flops per channel cost area but keep reads stable between strobes
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_hold
      mmr_sample_hold #(
        .WIDTH(32)
      ) mmr_sample_hold_i (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(chanLoad[ch]),
        .dataIn(chanIn[ch]),
        .dataOut(chanOut[ch])
      );
    end
  endgenerate

  // Freeze bit, written only through the sample control word
  // Freeze gates loads only; bus reads carry on as usual
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      freeze_reg <= 1'b0;
    end
    else if (ctrlWrite)
    begin
      freeze_reg <= apbReq.pwdata[`MMR_CTRL_FREEZE_BIT];
    end
  end

  // Capture flag: a new capture in the clearing cycle wins over the clear
  // Software clears it by writing 1 to bit 8, so a late clear cannot lose a capture
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      captured_reg <= 1'b0;
    end
    else if (chanLoad[MMR_CH_VOLTAGE])
    begin
      captured_reg <= 1'b1;
    end
    else if (ctrlWrite && apbReq.pwdata[`MMR_CTRL_CAPTURED_BIT])
    begin
      captured_reg <= 1'b0;
    end
  end

  // Count of accepted samples; wraps, so software compares two reads
  // Frozen strobes are not accepted and leave the count alone
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count_reg <= 16'h0000;
    end
    else if (sampleTake)
    begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Status and control word as software reads it
  // The ok flags follow the live codes, so a bad code shows before it is held
  always_comb
  begin
    ctrlWord = `MMR_RESET_WORD;
    ctrlWord[`MMR_CTRL_FREEZE_BIT] = freeze_reg;
    ctrlWord[`MMR_CTRL_CAPTURED_BIT] = captured_reg;
    ctrlWord[`MMR_CTRL_SPIN_ACTIVE_BIT] = spinActive;
    ctrlWord[`MMR_CTRL_GAIN_OK_BIT] = gainOk;
    ctrlWord[`MMR_CTRL_RANGE_OK_BIT] = rangeOk;
    ctrlWord[`MMR_CTRL_COUNT_MSB:`MMR_CTRL_COUNT_LSB] = count_reg;
  end

  // Read decode, taken in the setup phase so the data leaves a flip-flop
  // Writes decode too, so a write to an unmapped word is still refused
  always_comb
  begin
    prdata_next = `MMR_RESET_WORD;
    pslverr_next = 1'b0;
    if (!wordAligned)
    begin
      pslverr_next = 1'b1;
    end
    else
    begin
      case (regIndex)
        `MMR_IDX_THIRD_LEG_CURRENT:
        begin
          prdata_next = chanOut[MMR_CH_CURRENT];
        end
        `MMR_IDX_SENSE_AMP_GAIN:
        begin
          prdata_next = {16'h0000, chanOut[MMR_CH_GAIN][`MMR_CODE_MSB:`MMR_CODE_LSB]};
        end
        `MMR_IDX_VOLTAGE_RANGE:
        begin
          prdata_next = {16'h0000, chanOut[MMR_CH_RANGE][`MMR_CODE_MSB:`MMR_CODE_LSB]};
        end
        `MMR_IDX_SUPPLY_RAIL:
        begin
          prdata_next = chanOut[MMR_CH_SUPPLY];
        end
        `MMR_IDX_FIRST_LEG_VOLTAGE:
        begin
          prdata_next = chanOut[MMR_CH_VOLTAGE];
        end
        `MMR_IDX_SAMPLE_CONTROL:
        begin
          prdata_next = ctrlWord;
        end
        default:
        begin
          pslverr_next = 1'b1;
        end
      endcase
    end
    // Writes to readback words end cleanly with no error
    if (apbReq.pwrite)
    begin
      prdata_next = `MMR_RESET_WORD;
    end
  end

  // Bus state: every setup is answered in the following access cycle
  // No wait state is ever inserted, so the master never stalls here
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      MMR_IDLE:
      begin
        if (setupPhase)
        begin
          state_next = MMR_ACCESS;
        end
      end
      MMR_ACCESS:
      begin
        if (accessDone)
        begin
          state_next = MMR_IDLE;
        end
        else if (!apbReq.psel)
        begin
          // Master abandoned the transfer; wait for a fresh setup
          state_next = MMR_IDLE;
        end
      end
      default:
      begin
        state_next = MMR_IDLE;
      end
    endcase
  end

  // Bus state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg <= MMR_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Read data register, loaded only in the setup phase and held through access
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prdata_reg <= `MMR_RESET_WORD;
    end
    else if (state_reg == MMR_IDLE && setupPhase)
    begin
      prdata_reg <= prdata_next;
    end
  end

  // Error flag register, loaded with the data so both describe one address
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pslverr_reg <= 1'b0;
    end
    else if (state_reg == MMR_IDLE && setupPhase)
    begin
      pslverr_reg <= pslverr_next;
    end
  end

  // Ready is combinational so the access lasts exactly one cycle
  // Error only shows with ready, so an idle bus never flags a fault
  always_comb
  begin
    apbRsp.pready = accessDone;
    apbRsp.pslverr = accessDone && pslverr_reg;
    apbRsp.prdata = prdata_reg;
  end

endmodule

// ==== verification/mmr_readback_chk.sv ====
// Checker on the APB side of the measurement readback bank
`timescale 1ns/10ps
`include "mmr_params.svh"
module mmr_readback_chk
  import mmr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire mmr_apb_req_t apbReq,
  input wire mmr_apb_rsp_t apbRsp,
  input wire mmr_meas_t meas,
  input wire logic measStrobe,
  input wire logic [15:0] spinDetectState
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Setup cycle, and setup cycle aimed at one register index
  sequence setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence setupAt(logic [13:0] idx);
    setup and apbReq.paddr == {idx, 2'b00};
  endsequence

  a_ready_in_access: assert property (apbRsp.pready |-> apbReq.psel && apbReq.penable)
    else $error("ready outside an access cycle");
  a_zero_wait: assert property (setup |=> apbRsp.pready)
    else $error("access cycle not answered at once");
  a_gain_upper_zero: assert property (setupAt(`MMR_IDX_SENSE_AMP_GAIN) ##1 apbRsp.pready
    |-> apbRsp.prdata[31:16] == 16'h0000) else $error("gain report upper half set");
  a_range_upper_zero: assert property (setupAt(`MMR_IDX_VOLTAGE_RANGE) ##1 apbRsp.pready
    |-> apbRsp.prdata[31:16] == 16'h0000) else $error("range report upper half set");
  a_supply_no_err: assert property (setupAt(`MMR_IDX_SUPPLY_RAIL) ##1 apbRsp.pready
    |-> !apbRsp.pslverr) else $error("supply access gave an error");
  a_misalign_err: assert property (setup and apbReq.paddr[1:0] != 2'b00
    |=> apbRsp.pready && apbRsp.pslverr) else $error("misaligned access not refused");
  a_err_no_data: assert property (apbRsp.pready && apbRsp.pslverr |-> apbRsp.prdata == 32'h0)
    else $error("refused access returned data");
  // Reset itself is the antecedent here, so the default disable is overridden
  a_reset_clear: assert property (disable iff (1'b0) rst |=> apbRsp.prdata == 32'h0
    && !apbRsp.pready) else $error("bus answer not cleared by reset");
endmodule

bind mmr_readback mmr_readback_chk mmr_readback_chk_i
(
  .sys_clk(sys_clk),
  .rst(rst),
  .apbReq(apbReq),
  .apbRsp(apbRsp),
  .meas(meas),
  .measStrobe(measStrobe),
  .spinDetectState(spinDetectState)
);

// ==== verification/mmr_readback_test.sv ====
// Self-checking bench for the measurement readback bank
`timescale 1ns/10ps
`include "mmr_params.svh"
module mmr_readback_test
  import mmr_pkg::*;
;
  logic sys_clk;
  logic rst;
  mmr_apb_req_t req;
  mmr_apb_rsp_t rsp;
  mmr_meas_t meas;
  mmr_meas_t held;
  mmr_meas_t m;
  logic measStrobe;
  logic [15:0] spin;
  logic [31:0] seed;
  int err_count;
  int checks;
  mmr_word_t rd;
  logic er;
  logic [13:0] idxList [5];
  logic [15:0] cnt;
  logic cap;
  logic frz;

  mmr_readback mmr_readback_i
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .apbReq(req),
    .apbRsp(rsp),
    .meas(meas),
    .measStrobe(measStrobe),
    .spinDetectState(spin)
  );

  // Free-running 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Xorshift keeps the run repeatable
  function automatic mmr_word_t rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Word a read should return, from the values last loaded
  function automatic mmr_word_t expectWord(input logic [13:0] idx, input mmr_meas_t h);
    case (idx)
      `MMR_IDX_THIRD_LEG_CURRENT: return h.thirdLegCurrent;
      `MMR_IDX_SENSE_AMP_GAIN: return {16'h0000, h.senseAmpGainCode};
      `MMR_IDX_VOLTAGE_RANGE: return {16'h0000, h.voltageRangeCode};
      `MMR_IDX_SUPPLY_RAIL: return h.supplyRailLevel;
      default: return h.firstLegVoltage;
    endcase
  endfunction

  // Control word expected from the bench's own model and the live inputs
  function automatic mmr_word_t expectCtrl();
    logic gOk;
    logic rOk;
    gOk = (meas.senseAmpGainCode <= `MMR_GAIN_MAX_CODE);
    rOk = (meas.voltageRangeCode <= `MMR_RANGE_MAX_CODE);
    return {cnt, 4'h0, rOk, gOk, spin == `MMR_STATE_SPIN_DETECT, cap, 7'h00, frz};
  endfunction

  task automatic stop_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input mmr_word_t seen, input mmr_word_t exp);
    checks++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input mmr_addr_t a, input mmr_word_t d);
    int n;
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: 4'hF};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 8);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1)
    begin
      $display("Error pready expected 1 seen %b", rsp.pready);
      err_count++;
      stop_test();
    end
  endtask

  task automatic readAll();
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b0, {idxList[i], 2'b00}, 32'h0);
      chk("readback", rd, expectWord(idxList[i], held));
      chk("error", {31'h0, er}, 32'h0);
    end
    xfer(1'b0, {`MMR_IDX_SAMPLE_CONTROL, 2'b00}, 32'h0);
    chk("control", rd, expectCtrl());
  endtask

  // One strobe; the model follows only when loads are not frozen
  task automatic load(input mmr_meas_t v, input logic [15:0] sp);
    @(posedge sys_clk);
    meas <= v;
    measStrobe <= 1'b1;
    spin <= sp;
    @(posedge sys_clk);
    measStrobe <= 1'b0;
    meas <= ~v;
    if (!frz)
    begin
      cnt = cnt + 16'h0001;
      cap = cap | (sp == `MMR_STATE_SPIN_DETECT);
      held = (sp == `MMR_STATE_SPIN_DETECT) ? v : {v[127:32], held.firstLegVoltage};
    end
  endtask

  // Main sequence: reset values, random loads, writes, refusals
  initial
  begin
    rst = 1'b1;
    req = '0;
    meas = '0;
    held = '0;
    measStrobe = 1'b0;
    spin = 16'h0000;
    seed = 32'h00000F64;
    err_count = 0;
    checks = 0;
    cnt = 16'h0000;
    cap = 1'b0;
    frz = 1'b0;
    idxList = '{`MMR_IDX_THIRD_LEG_CURRENT, `MMR_IDX_SENSE_AMP_GAIN,
      `MMR_IDX_VOLTAGE_RANGE, `MMR_IDX_SUPPLY_RAIL, `MMR_IDX_FIRST_LEG_VOLTAGE};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    readAll();
    for (int i = 0; i < 24; i++)
    begin
      m = '{rnd(), 16'(i % 4), 16'(i % 3), rnd(), rnd()};
      load(m, (i % 2) ? `MMR_STATE_SPIN_DETECT : 16'(i));
      readAll();
    end
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, {idxList[i], 2'b00}, rnd());
      chk("write error", {31'h0, er}, 32'h0);
    end
    readAll();
    // Unmapped and misaligned reads are refused with no data
    for (int j = 0; j < 2; j++)
    begin
      xfer(1'b0, j ? {`MMR_IDX_SUPPLY_RAIL, 2'b10} : 16'h0004, 32'h0);
      chk("refused error", {31'h0, er}, 32'h1);
      chk("refused data", rd, 32'h0);
    end
    // Freeze blocks every load; writing bit 8 clears the capture flag
    xfer(1'b1, {`MMR_IDX_SAMPLE_CONTROL, 2'b00}, 32'h00000101);
    frz = 1'b1;
    cap = 1'b0;
    m = '{rnd(), 16'h0002, 16'h0001, rnd(), rnd()};
    load(m, `MMR_STATE_SPIN_DETECT);
    readAll();
    xfer(1'b1, {`MMR_IDX_SAMPLE_CONTROL, 2'b00}, 32'h00000000);
    frz = 1'b0;
    m = '{rnd(), 16'h0001, 16'h0002, rnd(), rnd()};
    load(m, `MMR_STATE_SPIN_DETECT);
    readAll();
    // Reset in mid-run clears every held value and the control state
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    held = '0;
    cnt = 16'h0000;
    cap = 1'b0;
    frz = 1'b0;
    readAll();
    stop_test();
  end
endmodule
